// File: design/pdc_defs.svh
// Constants of the power-down controller: offsets, bit positions, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

`define PDC_ADDR_W 8
`define PDC_CTL_OFS 8'h10
`define PDC_AUX_OFS 8'h14
`define PDC_CTL_W 6
`define PDC_CTL_RST 6'h00
`define PDC_SEL_W 4
`define PDC_BIT_POR_DIS 5
`define PDC_BIT_SLEEP 4
`define PDC_BIT_PIN 3
`define PDC_BIT_OSC 2
`define PDC_BIT_FAB 1
`define PDC_BIT_CPU 0
`define PDC_AUX_RING 0
`define PDC_AUX_SDOFF 1
`define PDC_AUX_SDPD 2
`define PDC_AUX_RESTART 3
`define PDC_CNT_W 8
`define PDC_CLK_NS 20
`define PDC_OSC_SETTLE_NS 200
`define PDC_SELFREF_NS 100
`define PDC_CYC_MIN(ns) (((ns) + `PDC_CLK_NS - 1) / `PDC_CLK_NS)
`define PDC_SETTLE_CYC `PDC_CYC_MIN(`PDC_OSC_SETTLE_NS)
`define PDC_SELFREF_CYC `PDC_CYC_MIN(`PDC_SELFREF_NS)

`endif

// File: design/pdc_pkg.sv
// Types shared by the power-down controller modules.
// Assumes pdc_defs.svh is on the include path.
`include "pdc_defs.svh"

package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_SD_ON = 2'b00,
    PDC_SD_SELFREF = 2'b01,
    PDC_SD_DOWN = 2'b10
  } pdc_sdram_t;

  typedef struct packed {
    logic [`PDC_CTL_W-1:0] ctl;
    logic ring;
    logic sd_off;
    pdc_sdram_t sd_state;
    logic [`PDC_CNT_W-1:0] sd_cnt;
    logic ack;
    logic [31:0] rdata;
    logic app_prev;
    logic rst_req;
  } pdc_main_state_t;

  typedef struct packed {
    logic fab_en;
    logic cpu_en;
    logic osc_stop;
    logic pin_off;
    logic settling;
    logic [`PDC_CNT_W-1:0] cnt;
  } pdc_gate_state_t;

endpackage

// File: design/pdc_gate_if.sv
// Carrier between the register side and the gate sequencer.
// Assumes both ends run on the same clock.
`include "pdc_defs.svh"

interface pdc_gate_if;
  logic sleep_next;
  logic [`PDC_SEL_W-1:0] sel;
  logic fab_en;
  logic cpu_en;
  logic osc_stop;
  logic pin_off;
  logic restarting;

  modport ctrl (
    output sleep_next, sel,
    input fab_en, cpu_en, osc_stop, pin_off, restarting
  );
  modport gate (
    input sleep_next, sel,
    output fab_en, cpu_en, osc_stop, pin_off, restarting
  );
endinterface

// File: design/pdc_sync.sv
// Two-flop synchroniser for asynchronous wake and reset inputs.
// Assumes inputs are levels held for more than two clocks.

module pdc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pdc_sync_state_t;

  pdc_sync_state_t r_reg;
  pdc_sync_state_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;

endmodule // pdc_sync

// File: design/pdc_gate_seq.sv
// Clock-enable and shutdown sequencer for power down.
// Assumes enables feed latch-based clock gates downstream.
`include "pdc_defs.svh"

module pdc_gate_seq #(
  parameter int SETTLE_CYC = `PDC_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pdc_gate_if.gate g
);

  localparam logic [`PDC_CNT_W-1:0] SETTLE_LAST = `PDC_CNT_W'(SETTLE_CYC - 1);

  pdc_pkg::pdc_gate_state_t r_reg;
  pdc_pkg::pdc_gate_state_t r_next;

  always_comb begin
    r_next = r_reg;
    if (g.sleep_next) begin
      // Applied on the same edge that sets the request
      r_next.fab_en = ~g.sel[`PDC_BIT_FAB]; // RL6 RL2
      r_next.cpu_en = ~g.sel[`PDC_BIT_CPU]; // RL7 RL2
      r_next.osc_stop = g.sel[`PDC_BIT_OSC]; // RL5
      r_next.pin_off = g.sel[`PDC_BIT_PIN]; // RL4
      r_next.settling = 1'b0;
      r_next.cnt = '0;
    end else begin
      r_next.osc_stop = 1'b0; // RL9
      r_next.pin_off = 1'b0; // RL9
      if (!r_reg.fab_en || !r_reg.cpu_en) begin
        // Oscillator must settle before the clocks come back
        if (r_reg.cnt == SETTLE_LAST) begin
          r_next.fab_en = 1'b1; // RL16
          r_next.cpu_en = 1'b1; // RL16
          r_next.settling = 1'b0;
          r_next.cnt = '0;
        end else begin
          r_next.settling = 1'b1;
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '{fab_en: 1'b1, cpu_en: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Enables only move at an edge, so a downstream gate never slivers
  assign g.fab_en = r_reg.fab_en;
  assign g.cpu_en = r_reg.cpu_en;
  assign g.osc_stop = r_reg.osc_stop;
  assign g.pin_off = r_reg.pin_off;
  assign g.restarting = r_reg.settling;

endmodule // pdc_gate_seq

// File: design/pdc_power_down_controller.sv
// Power-down controller: control register, wake logic, SDRAM shutdown.
// Assumes an Avalon-MM master on MCLK_I and asynchronous wake pins.
`include "pdc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// RL1 - Request bit four enters power down
// RL2 - Selected shutdowns apply on the setting edge
// RL3 - Bit five disables the power-on reset circuit
// RL4 - Bit three disables design-marked pins in sleep
// RL5 - Bit two stops ring oscillator in sleep
// RL6 - Bit one gates fabric bus clock in sleep
// RL7 - Bit zero gates CPU bus clock in sleep
// RL8 - System reset clears control register
// RL9 - Any interrupt clears request, re-enables circuits
// RL10 - Application reset clears all, requests system reset
// RL11 - Software quiesces DMA and memories first
// RL12 - SDRAM off: self-refresh, then power down
// RL13 - Software disables synthesizer and crystal first
// RL14 - Software slows memory timing before switching
// RL15 - Wake runs system from ring oscillator
// RL16 - Wake synchronised, clocks restart glitch-free
// RL17 - Bits thirty-one to six read zero
module pdc_power_down_controller #(
  parameter int N_IRQ = 4,
  parameter int N_PIN = 8,
  parameter logic [N_PIN-1:0] PIN_SLEEP_MASK = '1,
  parameter int SETTLE_CYC = `PDC_SETTLE_CYC,
  parameter int SELFREF_CYC = `PDC_SELFREF_CYC
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [`PDC_ADDR_W-1:0] AV_ADDRESS_I,
  input wire logic AV_READ_I,
  input wire logic AV_WRITE_I,
  input wire logic [31:0] AV_WRITEDATA_I,
  input wire logic [3:0] AV_BYTEENABLE_I,
  output logic [31:0] AV_READDATA_O,
  output logic AV_WAITREQUEST_O,
  input wire logic [2:0] FABRIC_IRQ_I,
  input wire logic [N_IRQ-1:0] SYS_IRQ_I,
  input wire logic APPLICATION_RESET_SIDEBAND_I,
  output logic SLEEP_ACTIVE_O,
  output logic POR_DISABLE_O,
  output logic [N_PIN-1:0] PIN_DISABLE_O,
  output logic RING_OSC_STOP_O,
  output logic FABRIC_CLK_EN_O,
  output logic CPU_CLK_EN_O,
  output logic CLK_SRC_RING_O,
  output logic SDRAM_SELF_REFRESH_O,
  output logic SDRAM_POWER_DOWN_O,
  output logic SYS_RESET_REQ_O
);

  localparam int SYNC_W = N_IRQ + 4;
  localparam int RESTART_MAX = SETTLE_CYC + 1;
  localparam logic [`PDC_CNT_W-1:0] SR_LAST = `PDC_CNT_W'(SELFREF_CYC - 1);

  pdc_pkg::pdc_main_state_t r_reg;
  pdc_pkg::pdc_main_state_t r_next;
  pdc_gate_if gif ();

  logic [SYNC_W-1:0] sync_q;
  logic irq_any;
  logic app_sync;
  logic req;
  logic wr_acc;
  logic wr_ctl;
  logic wr_aux;

  //////////////////////////////////////////////////////////////////////////////
  // Wake inputs
  // Interrupt pins are asynchronous; two flops before any use
  pdc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .d_i({APPLICATION_RESET_SIDEBAND_I, FABRIC_IRQ_I, SYS_IRQ_I}),
    .q_o(sync_q)
  );

  assign irq_any = |sync_q[SYNC_W-2:0]; // RL9 RL16
  assign app_sync = sync_q[SYNC_W-1];

  //////////////////////////////////////////////////////////////////////////////
  // Gate sequencer
  pdc_gate_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_gate (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .g(gif.gate)
  );

  assign gif.sleep_next = r_next.ctl[`PDC_BIT_SLEEP]; // RL2
  assign gif.sel = r_next.ctl[`PDC_SEL_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // One wait state: data are loaded on the first edge, taken on the second
  assign req = AV_READ_I | AV_WRITE_I;
  assign AV_WAITREQUEST_O = req & ~r_reg.ack;
  assign wr_acc = AV_WRITE_I & r_reg.ack & AV_BYTEENABLE_I[0];
  assign wr_ctl = wr_acc && (AV_ADDRESS_I == `PDC_CTL_OFS);
  assign wr_aux = wr_acc && (AV_ADDRESS_I == `PDC_AUX_OFS);

  always_comb begin
    r_next = r_reg;
    r_next.ack = req & ~r_reg.ack;
    r_next.rst_req = 1'b0;
    r_next.app_prev = app_sync;
    if (AV_READ_I && !r_reg.ack) begin
      r_next.rdata = '0; // RL17
      if (AV_ADDRESS_I == `PDC_CTL_OFS) begin
        r_next.rdata[`PDC_CTL_W-1:0] = r_reg.ctl;
      end else if (AV_ADDRESS_I == `PDC_AUX_OFS) begin
        r_next.rdata[`PDC_AUX_RING] = r_reg.ring;
        r_next.rdata[`PDC_AUX_SDOFF] = r_reg.sd_off;
        r_next.rdata[`PDC_AUX_SDPD] = (r_reg.sd_state == pdc_pkg::PDC_SD_DOWN);
        r_next.rdata[`PDC_AUX_RESTART] = gif.restarting;
      end
    end
    if (wr_ctl) begin
      r_next.ctl = AV_WRITEDATA_I[`PDC_CTL_W-1:0]; // RL1 RL3 RL17
    end
    if (wr_aux) begin
      r_next.ring = AV_WRITEDATA_I[`PDC_AUX_RING];
      r_next.sd_off = AV_WRITEDATA_I[`PDC_AUX_SDOFF];
    end
    // SDRAM shutdown: self-refresh first so data survive
    case (r_reg.sd_state)
      pdc_pkg::PDC_SD_ON: begin
        if (r_reg.sd_off) begin
          r_next.sd_state = pdc_pkg::PDC_SD_SELFREF; // RL12
          r_next.sd_cnt = '0;
        end
      end
      pdc_pkg::PDC_SD_SELFREF: begin
        if (!r_reg.sd_off) begin
          r_next.sd_state = pdc_pkg::PDC_SD_ON;
        end else if (r_reg.sd_cnt == SR_LAST) begin
          r_next.sd_state = pdc_pkg::PDC_SD_DOWN; // RL12
        end else begin
          r_next.sd_cnt = r_reg.sd_cnt + 1'b1;
        end
      end
      pdc_pkg::PDC_SD_DOWN: begin
        if (!r_reg.sd_off) begin
          r_next.sd_state = pdc_pkg::PDC_SD_ON;
        end
      end
      default: begin
        r_next.sd_state = pdc_pkg::PDC_SD_ON;
      end
    endcase
    // Interrupt beats a software write of the request in the same cycle
    if (irq_any) begin
      r_next.ctl[`PDC_BIT_SLEEP] = 1'b0; // RL9
      if (r_reg.ctl[`PDC_BIT_SLEEP]) begin
        r_next.ring = 1'b1; // RL15
      end
    end
    // Application reset dominates everything
    if (app_sync) begin
      r_next.ctl = `PDC_CTL_RST; // RL10
      r_next.ring = 1'b0;
      r_next.sd_off = 1'b0;
      r_next.sd_state = pdc_pkg::PDC_SD_ON;
      r_next.ack = 1'b0;
      r_next.rst_req = ~r_reg.app_prev; // RL10
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      r_reg <= '{ctl: `PDC_CTL_RST, sd_state: pdc_pkg::PDC_SD_ON, default: '0}; // RL8
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AV_READDATA_O = r_reg.rdata;
  assign SLEEP_ACTIVE_O = r_reg.ctl[`PDC_BIT_SLEEP]; // RL1
  assign POR_DISABLE_O = r_reg.ctl[`PDC_BIT_POR_DIS]; // RL3
  assign PIN_DISABLE_O = {N_PIN{gif.pin_off}} & PIN_SLEEP_MASK; // RL4
  assign RING_OSC_STOP_O = gif.osc_stop;
  assign FABRIC_CLK_EN_O = gif.fab_en;
  assign CPU_CLK_EN_O = gif.cpu_en;
  assign CLK_SRC_RING_O = r_reg.ring; // RL15
  assign SDRAM_SELF_REFRESH_O = (r_reg.sd_state == pdc_pkg::PDC_SD_SELFREF);
  assign SDRAM_POWER_DOWN_O = (r_reg.sd_state == pdc_pkg::PDC_SD_DOWN);
  assign SYS_RESET_REQ_O = r_reg.rst_req;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  sequence s_ctl_wr;
    wr_ctl && !irq_any && !app_sync;
  endsequence

  sequence s_wake;
    irq_any && SLEEP_ACTIVE_O && !app_sync;
  endsequence

  property p_sleep_enter;
    s_ctl_wr ##0 AV_WRITEDATA_I[`PDC_BIT_SLEEP] |=> SLEEP_ACTIVE_O;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered"); // RL1

  property p_cpu_gate_now;
    s_ctl_wr ##0 (AV_WRITEDATA_I[`PDC_BIT_SLEEP] && AV_WRITEDATA_I[`PDC_BIT_CPU])
      |=> !CPU_CLK_EN_O;
  endproperty
  a_cpu_gate_now: assert property (p_cpu_gate_now) else $error("cpu clock not gated"); // RL2 RL7

  property p_por_dis;
    s_ctl_wr ##0 AV_WRITEDATA_I[`PDC_BIT_POR_DIS] |=> POR_DISABLE_O;
  endproperty
  a_por_dis: assert property (p_por_dis) else $error("reset circuit not disabled"); // RL3

  property p_pins_only_sleep;
    (PIN_DISABLE_O != '0) |-> SLEEP_ACTIVE_O && r_reg.ctl[`PDC_BIT_PIN];
  endproperty
  a_pins_only_sleep: assert property (p_pins_only_sleep) else $error("pins off awake"); // RL4

  property p_osc_only_sleep;
    RING_OSC_STOP_O |-> SLEEP_ACTIVE_O && r_reg.ctl[`PDC_BIT_OSC];
  endproperty
  a_osc_only_sleep: assert property (p_osc_only_sleep) else $error("osc stopped awake"); // RL5

  property p_fab_gate;
    !FABRIC_CLK_EN_O && !gif.restarting |-> SLEEP_ACTIVE_O || $past(SLEEP_ACTIVE_O);
  endproperty
  a_fab_gate: assert property (p_fab_gate) else $error("fabric clock gated awake"); // RL6

  property p_reset_zero;
    disable iff (1'b0) SYS_RST_I |=> (r_reg.ctl == `PDC_CTL_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not cleared"); // RL8

  property p_wake;
    s_wake |=> !SLEEP_ACTIVE_O && CLK_SRC_RING_O && !RING_OSC_STOP_O;
  endproperty
  a_wake: assert property (p_wake) else $error("wake failed"); // RL9 RL15

  property p_app_reset;
    $rose(app_sync) |=> SYS_RESET_REQ_O && (r_reg.ctl == `PDC_CTL_RST) ##1 !SYS_RESET_REQ_O;
  endproperty
  a_app_reset: assert property (p_app_reset) else $error("app reset mishandled"); // RL10

  property p_selfref_first;
    $rose(SDRAM_POWER_DOWN_O) |-> $past(SDRAM_SELF_REFRESH_O);
  endproperty
  a_selfref_first: assert property (p_selfref_first) else $error("no self-refresh"); // RL12

  property p_restart;
    $fell(SLEEP_ACTIVE_O) ##0 !app_sync
      |-> ##[1:RESTART_MAX] (FABRIC_CLK_EN_O && CPU_CLK_EN_O);
  endproperty
  a_restart: assert property (p_restart) else $error("clocks not restarted"); // RL16

  property p_reserved;
    AV_READ_I && !AV_WAITREQUEST_O |-> (AV_READDATA_O[31:`PDC_CTL_W] == '0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set"); // RL17

  sequence s_sd_req;
    (r_reg.sd_state == pdc_pkg::PDC_SD_ON) && r_reg.sd_off && !app_sync;
  endsequence

  property p_fab_gate_now;
    s_ctl_wr ##0 (AV_WRITEDATA_I[`PDC_BIT_SLEEP] && AV_WRITEDATA_I[`PDC_BIT_FAB])
      |=> !FABRIC_CLK_EN_O;
  endproperty
  a_fab_gate_now: assert property (p_fab_gate_now) else $error("fabric not gated"); // RL2 RL6

  property p_osc_stop_now;
    s_ctl_wr ##0 (AV_WRITEDATA_I[`PDC_BIT_SLEEP] && AV_WRITEDATA_I[`PDC_BIT_OSC])
      |=> RING_OSC_STOP_O;
  endproperty
  a_osc_stop_now: assert property (p_osc_stop_now) else $error("osc not stopped"); // RL2 RL5

  property p_pins_now;
    s_ctl_wr ##0 (AV_WRITEDATA_I[`PDC_BIT_SLEEP] && AV_WRITEDATA_I[`PDC_BIT_PIN])
      |=> (PIN_DISABLE_O == PIN_SLEEP_MASK);
  endproperty
  a_pins_now: assert property (p_pins_now) else $error("pins not disabled"); // RL2 RL4

  property p_awake;
    s_ctl_wr ##0 !AV_WRITEDATA_I[`PDC_BIT_SLEEP]
      |=> !SLEEP_ACTIVE_O && !RING_OSC_STOP_O && (PIN_DISABLE_O == '0);
  endproperty
  a_awake: assert property (p_awake) else $error("sleep without request"); // RL1

  property p_irq_wins;
    irq_any && !app_sync |=> !SLEEP_ACTIVE_O;
  endproperty
  a_irq_wins: assert property (p_irq_wins) else $error("interrupt lost to write"); // RL9

  property p_selfref_enter;
    s_sd_req |=> SDRAM_SELF_REFRESH_O && !SDRAM_POWER_DOWN_O;
  endproperty
  a_selfref_enter: assert property (p_selfref_enter) else $error("sdram not parked"); // RL12

endmodule // pdc_power_down_controller

// File: verification/tb_top.sv
// Self-checking bench for the power-down controller: register table rows, wake, resets.
// Assumes the design files are compiled first; the bench plays the Avalon master.
`include "pdc_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] w;
    logic [5:0] rd;
    logic [7:0] pin;
    logic [4:0] fl;
  } pdc_row_t;

  logic clk, rst, rd_en, wr_en, app_rst, waitreq;
  logic [7:0] addr, pin;
  logic [31:0] wdata, rdata, q;
  logic [2:0] fab_irq;
  logic [3:0] sys_irq;
  logic [3:0] be;
  logic sleep, por, osc_stop, fab_en, cpu_en, src_ring, sd_sr, sd_pd, rst_req;
  int error_cnt, checked, n, sr_cnt;
  // Row flags: sleep, por, osc stop, fabric clock, cpu clock
  pdc_row_t rows [8] = '{
    '{32'hFFFFFFFF, 6'h3F, 8'hA5, 5'h1C}, '{32'h00000010, 6'h10, 8'h00, 5'h13},
    '{32'h0000000F, 6'h0F, 8'h00, 5'h03}, '{32'h00000011, 6'h11, 8'h00, 5'h12},
    '{32'h00000012, 6'h12, 8'h00, 5'h11}, '{32'h00000014, 6'h14, 8'h00, 5'h17},
    '{32'h00000018, 6'h18, 8'hA5, 5'h13}, '{32'h00000020, 6'h20, 8'h00, 5'h0B}};

  ////////////////////////////////////////////////////////////////////////////////
  // Small settle counts keep the run short; mask marks only some pins
  pdc_power_down_controller #(.N_IRQ(4), .N_PIN(8), .PIN_SLEEP_MASK(8'hA5),
    .SETTLE_CYC(2), .SELFREF_CYC(1)) dut_u (
    .MCLK_I(clk), .SYS_RST_I(rst), .AV_ADDRESS_I(addr), .AV_READ_I(rd_en),
    .AV_WRITE_I(wr_en), .AV_WRITEDATA_I(wdata), .AV_BYTEENABLE_I(be),
    .AV_READDATA_O(rdata), .AV_WAITREQUEST_O(waitreq), .FABRIC_IRQ_I(fab_irq),
    .SYS_IRQ_I(sys_irq), .APPLICATION_RESET_SIDEBAND_I(app_rst),
    .SLEEP_ACTIVE_O(sleep), .POR_DISABLE_O(por), .PIN_DISABLE_O(pin),
    .RING_OSC_STOP_O(osc_stop), .FABRIC_CLK_EN_O(fab_en), .CPU_CLK_EN_O(cpu_en),
    .CLK_SRC_RING_O(src_ring), .SDRAM_SELF_REFRESH_O(sd_sr),
    .SDRAM_POWER_DOWN_O(sd_pd), .SYS_RESET_REQ_O(rst_req));

  always #10 clk = ~clk;

  // One-cycle pulse would slip past the bus task, so count it here
  always @(posedge clk) begin
    if (sd_sr === 1'b1) sr_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Entered just after a rising edge; the request stands until waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    wr_en <= wr;
    rd_en <= !wr;
    addr <= a;
    wdata <= d;
    // Waitrequest and read data are taken at the rising edge; a hang is the watchdog's
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    fab_irq = 3'h0;
    sys_irq = 4'h0;
    be = 4'hF;
    app_rst = 1'b0;
    error_cnt = 0;
    checked = 0;
    sr_cnt = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({sleep, por, osc_stop, fab_en, cpu_en, pin, src_ring, sd_sr, sd_pd}, 16'h1800)
    @(posedge clk);
    bus(1'b0, `PDC_CTL_OFS, 32'h0);
    `CHK(q, 32'h0)
    // Unmapped place and a write without lane 0 must leave the control word alone
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    be <= 4'hE;
    bus(1'b1, `PDC_CTL_OFS, 32'hFFFFFFFF);
    be <= 4'hF;
    bus(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, `PDC_CTL_OFS, 32'h0);
    `CHK(q, 32'h0)
    foreach (rows[i]) begin
      bus(1'b1, `PDC_CTL_OFS, rows[i].w);
      @(negedge clk);
      `CHK({sleep, por, osc_stop, fab_en, cpu_en}, rows[i].fl)
      `CHK(pin, rows[i].pin)
      @(posedge clk);
      bus(1'b0, `PDC_CTL_OFS, 32'h0);
      `CHK(q, {26'h0, rows[i].rd})
      bus(1'b1, `PDC_CTL_OFS, 32'h0);
      repeat (4) @(posedge clk);
    end
    // Every wake line, system and fabric alike
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `PDC_CTL_OFS, 32'h1F);
      {sys_irq, fab_irq} <= 7'h01 << i;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK({sleep, osc_stop, pin, fab_en, src_ring}, 12'h001)
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK({fab_en, cpu_en}, 2'h3)
      @(posedge clk);
      bus(1'b1, `PDC_CTL_OFS, 32'h1F);
      @(negedge clk);
      `CHK(sleep, 1'b0)
      @(posedge clk);
      {sys_irq, fab_irq} <= 7'h00;
      bus(1'b0, `PDC_CTL_OFS, 32'h0);
      `CHK(q, 32'h0F)
      bus(1'b0, `PDC_AUX_OFS, 32'h0);
      `CHK(q[0], 1'b1)
      bus(1'b1, `PDC_AUX_OFS, 32'h0);
    end
    // Software order before sleep: memories parked, ring clock, selections, request last
    n = sr_cnt;
    bus(1'b1, `PDC_AUX_OFS, 32'h03);
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(sr_cnt - n, 1)
    `CHK({sd_sr, sd_pd}, 2'h1)
    @(posedge clk);
    bus(1'b1, `PDC_CTL_OFS, 32'h2F);
    @(negedge clk);
    `CHK({sleep, por, cpu_en, src_ring}, 4'h7)
    @(posedge clk);
    bus(1'b1, `PDC_CTL_OFS, 32'h3F);
    // Application reset in mid power down, SDRAM still off
    app_rst <= 1'b1;
    n = 0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      if (rst_req === 1'b1) n++;
    end
    `CHK(n, 1)
    `CHK({sleep, por, fab_en, cpu_en, sd_sr, sd_pd}, 6'h0C)
    @(posedge clk);
    app_rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, `PDC_CTL_OFS, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, `PDC_AUX_OFS, 32'h0);
    `CHK(q, 32'h0)
    // System reset in mid-run, asleep with everything selected
    bus(1'b1, `PDC_CTL_OFS, 32'h3F);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK({sleep, por, osc_stop, fab_en, cpu_en, pin, src_ring, sd_sr, sd_pd}, 16'h1800)
    @(posedge clk);
    bus(1'b0, `PDC_CTL_OFS, 32'h0);
    `CHK(q, 32'h0)
    give_verdict();
  end
endmodule // tb_top
